/* src/php_access_decode.sv */
// maps the shared strobe pins onto start, direction and end of access
// assumes pins already in the pclk domain
`timescale 1ns/1ps
module php_access_decode (
	input wire logic single_style,
	input wire logic cs_n,
	input wire logic wr_rw,
	input wire logic rd_ds_n,
	output logic start,
	output logic is_read,
	output logic ended
);
	wire sep_active = !rd_ds_n || !wr_rw;

	// ----------------------------------------------------------------
	// style remap of shared pins
	// ----------------------------------------------------------------
	assign start = !cs_n && (single_style ? !rd_ds_n : sep_active);
	assign is_read = single_style ? wr_rw : !rd_ds_n;
	assign ended = cs_n || (single_style ? rd_ds_n : !sep_active);
endmodule : php_access_decode

/* src/php_device.sv */
// device end of the parallel host port: decodes host accesses,
// holds the chip access control byte, serves output words locally
// and forwards other addresses below 0xe8 to an internal register port.
// assumes pclk is the host-supplied port clock; straps and mode pins
// are asynchronous and are synchronised here.
//
// Our own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
// Behaviour
// - act on rising port clock, outside reset
// - port works only with serial select low
// - eight-bit address reaches every register directly
// - bus width 8 or 16 from control register
// - host keeps port clock below limits
// - style pin remaps strobes, ready/acknowledge
// - separate read/write strobes give type, validity
// - ready pulled low during access, then released
// - host drives writes, device drives reads
// - host never touches 0xe8 to 0xff
// - separate write: strobe, select, wait ready
// - separate read: float bus, capture after ready
// - direction high reads, data strobe marks validity
// - acknowledge low at end, release on deselect
// - single write: strobes, select, wait acknowledge
// - single read: acknowledge once data valid
// - complete only when chip id matches pins; the control byte at 0x02 completes whatever the id
// - shared bus needs distinct id straps
// - chip select frames every access
// - output words readable through port
// - unused bits read undefined, write zero
module php_device #(
	parameter int ADDR_W = php_pkg::ADDR_W,
	parameter int DATA_W = php_pkg::DATA_W,
	parameter int ID_W = php_pkg::ID_W
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	php_port_if.device port,
	input wire logic [DATA_W-1:0] out_i_word,
	input wire logic [DATA_W-1:0] out_q_word,
	input wire logic [DATA_W-1:0] signal_strength_word,
	output logic reg_req,
	output logic reg_write,
	output logic reg_wide,
	output logic [ADDR_W-1:0] reg_addr,
	output logic [DATA_W-1:0] reg_wdata,
	input wire logic [DATA_W-1:0] reg_rdata,
	input wire logic reg_done,
	output logic [7:0] chip_ctrl,
	output logic busy
);

	// ----------------------------------------------------------------
	// elaboration checks
	// ----------------------------------------------------------------
	if (ADDR_W != 8 || DATA_W != 16 || ID_W != 4) begin : g_bad_width
		$error("php_device supports only 8-bit address, 16-bit data, 4-bit id");
	end

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic [ID_W+1:0] pin_meta_reg;
	logic [ID_W+1:0] pin_sync_reg;
	php_pkg::php_dev_state_t state_reg;
	logic [7:0] chip_ctrl_reg;
	logic [ADDR_W-1:0] addr_reg;
	logic read_reg;
	logic wide_reg;
	logic [DATA_W-1:0] wdata_reg;
	logic [DATA_W-1:0] dev_d_reg;
	logic [1:0] dev_d_oe_reg;
	logic ack_oe_reg;
	logic req_reg;
	logic start;
	logic is_read;
	logic ended;

	wire serial_sel_s = pin_sync_reg[ID_W+1];
	wire single_style = pin_sync_reg[ID_W];
	wire [ID_W-1:0] id_pins_s = pin_sync_reg[ID_W-1:0];
	wire port_on = !serial_sel_s;
	wire wide_mode = chip_ctrl_reg[php_pkg::CC_WIDE_BIT];
	wire [ID_W-1:0] id_field = chip_ctrl_reg[php_pkg::CC_ID_LSB +: ID_W];
	wire ctrl_hit = port.addr == php_pkg::ADDR_CHIP_CTRL;
	// control byte always reachable, else only a device strapped to id 0 could ever be selected
	wire id_match = (id_field == id_pins_s) || ctrl_hit;
	wire hang_hit = port.addr >= php_pkg::ADDR_FIRST_HANG;
	wire [DATA_W-1:0] lane_mask = wide_mode ? 16'hffff : 16'h00ff;
	wire [DATA_W-1:0] wdata_in = port.data_line & lane_mask;
	wire is_i = addr_reg == php_pkg::ADDR_OUT_I;
	wire is_q = addr_reg == php_pkg::ADDR_OUT_Q;
	wire is_pwr = addr_reg == php_pkg::ADDR_OUT_PWR;
	wire is_ctrl = addr_reg == php_pkg::ADDR_CHIP_CTRL;
	wire local_hit = is_i || is_q || is_pwr || is_ctrl;
	// upper byte of the control word is not stored here and reads zero
	wire [DATA_W-1:0] local_rdata = is_ctrl ? {8'h00, chip_ctrl_reg} :
		is_i ? out_i_word :
		is_q ? out_q_word :
		signal_strength_word;
	wire [DATA_W-1:0] local_rd_masked = local_rdata & (wide_reg ? 16'hffff : 16'h00ff);
	wire [DATA_W-1:0] ext_rd_masked = reg_rdata & (wide_reg ? 16'hffff : 16'h00ff);
	wire [1:0] drive_lanes = wide_reg ? 2'b11 : 2'b01;

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_meta_reg <= '0;
			pin_sync_reg <= '0;
		end else if (ce) begin
			pin_meta_reg <= {port.serial_sel, port.style, port.dev_id};
			pin_sync_reg <= pin_meta_reg;
		end
	end

	php_access_decode u_decode (
		.single_style(single_style),
		.cs_n(port.cs_n),
		.wr_rw(port.wr_rw),
		.rd_ds_n(port.rd_ds_n),
		.start(start),
		.is_read(is_read),
		.ended(ended)
	);

	// ----------------------------------------------------------------
	// access sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= php_pkg::DV_IDLE;
			chip_ctrl_reg <= php_pkg::CC_RESET;
			addr_reg <= '0;
			read_reg <= 1'b0;
			wide_reg <= 1'b0;
			wdata_reg <= '0;
			dev_d_reg <= '0;
			dev_d_oe_reg <= 2'b00;
			ack_oe_reg <= 1'b0;
			req_reg <= 1'b0;
		end else if (ce) begin
			if (!port_on) begin
				// serial port owns the shared pins: drop the access and request, release data and ready
				state_reg <= php_pkg::DV_IDLE;
				dev_d_oe_reg <= 2'b00;
				ack_oe_reg <= 1'b0;
				req_reg <= 1'b0;
			end else begin
				case (state_reg)
					php_pkg::DV_IDLE: begin
						if (start) begin
							addr_reg <= port.addr;
							read_reg <= is_read;
							wide_reg <= wide_mode;
							wdata_reg <= wdata_in;
							if (!id_match) begin
								state_reg <= php_pkg::DV_IGNORE;
							end else begin
								ack_oe_reg <= !single_style;
								state_reg <= hang_hit ? php_pkg::DV_HANG : php_pkg::DV_BUSY;
							end
						end
					end
					php_pkg::DV_BUSY: begin
						if (local_hit) begin
							if (read_reg) begin
								dev_d_reg <= local_rd_masked;
							end else if (is_ctrl) begin
								chip_ctrl_reg <= wdata_reg[7:0];
							end
							dev_d_oe_reg <= read_reg ? drive_lanes : 2'b00;
							ack_oe_reg <= single_style;
							state_reg <= php_pkg::DV_DONE;
						end else begin
							req_reg <= 1'b1;
							state_reg <= php_pkg::DV_WAIT;
						end
					end
					php_pkg::DV_WAIT: begin
						req_reg <= 1'b0;
						if (reg_done) begin
							dev_d_reg <= ext_rd_masked;
							dev_d_oe_reg <= read_reg ? drive_lanes : 2'b00;
							ack_oe_reg <= single_style;
							state_reg <= php_pkg::DV_DONE;
						end
					end
					php_pkg::DV_DONE, php_pkg::DV_IGNORE, php_pkg::DV_HANG: begin
						// a hang keeps ready low until the host gives up
						if (ended) begin
							dev_d_oe_reg <= 2'b00;
							ack_oe_reg <= 1'b0;
							state_reg <= php_pkg::DV_IDLE;
						end
					end
					default: begin
						state_reg <= php_pkg::DV_IDLE;
					end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign port.dev_d = dev_d_reg;
	assign port.dev_d_oe = dev_d_oe_reg;
	// open drain only ever pulls low
	assign port.ack_o = 1'b0;
	assign port.ack_oe = ack_oe_reg;
	assign reg_req = req_reg;
	assign reg_write = !read_reg;
	assign reg_wide = wide_reg;
	assign reg_addr = addr_reg;
	assign reg_wdata = wdata_reg;
	assign chip_ctrl = chip_ctrl_reg;
	assign busy = state_reg != php_pkg::DV_IDLE;

endmodule : php_device

/* src/php_host.sv */
// host end of the parallel host port, run from apb registers
// assumes pclk also clocks the device and stays below the port clock limit
`timescale 1ns/1ps
module php_host (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	php_port_if.host port
);

	// ----------------------------------------------------------------
	// apb slave
	// ----------------------------------------------------------------
	php_pkg::php_host_state_t state_reg;
	logic pready_reg;
	logic pslverr_reg;
	logic [31:0] prdata_reg;
	logic [8:0] cmd_reg;
	logic [15:0] wdata_reg;
	logic [15:0] rdata_reg;
	logic done_reg;
	logic [2:0] cfg_reg;
	logic seen_low_reg;
	logic cs_n_reg;
	logic wr_rw_reg;
	logic rd_ds_n_reg;
	logic [1:0] d_oe_reg;

	wire setup = psel && !penable && !pready_reg;
	wire xfer = psel && penable && pready_reg;
	wire hit_cmd = paddr == php_pkg::HR_CMD;
	wire hit_wdata = paddr == php_pkg::HR_WDATA;
	wire hit_rdata = paddr == php_pkg::HR_RDATA;
	wire hit_status = paddr == php_pkg::HR_STATUS;
	wire hit_config = paddr == php_pkg::HR_CONFIG;
	wire mapped = hit_cmd || hit_wdata || hit_rdata || hit_status || hit_config;
	wire busy = state_reg != php_pkg::HS_IDLE;
	wire [31:0] rd_mux = hit_cmd ? {23'h0, cmd_reg} :
		hit_wdata ? {16'h0, wdata_reg} :
		hit_rdata ? {16'h0, rdata_reg} :
		hit_status ? {30'h0, done_reg, busy} :
		hit_config ? {29'h0, cfg_reg} : 32'h0;
	wire go = xfer && pwrite && hit_cmd && pwdata[php_pkg::CMD_GO_BIT] && !busy;
	wire single = cfg_reg[php_pkg::CFG_STYLE_BIT];
	wire wide = cfg_reg[php_pkg::CFG_WIDE_BIT];
	wire is_read = cmd_reg[php_pkg::CMD_READ_BIT];
	wire sep_end = seen_low_reg && port.ack_line;
	wire finish = state_reg == php_pkg::HS_WAIT && (single ? !port.ack_line : sep_end);
	wire set_done = finish;
	wire clr_done = xfer && pwrite && hit_status && pwdata[php_pkg::ST_DONE_BIT];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= '0;
		end else if (ce) begin
			pready_reg <= setup;
			pslverr_reg <= setup && !mapped;
			if (setup) begin
				prdata_reg <= rd_mux;
			end
		end
	end

	// ----------------------------------------------------------------
	// registers and port sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= php_pkg::HS_IDLE;
			cmd_reg <= '0;
			wdata_reg <= '0;
			rdata_reg <= '0;
			done_reg <= 1'b0;
			cfg_reg <= php_pkg::CFG_RESET;
			seen_low_reg <= 1'b0;
			cs_n_reg <= 1'b1;
			wr_rw_reg <= 1'b1;
			rd_ds_n_reg <= 1'b1;
			d_oe_reg <= 2'b00;
		end else if (ce) begin
			if (xfer && pwrite && hit_wdata) begin
				wdata_reg <= pwdata[15:0];
			end
			if (xfer && pwrite && hit_config && !busy) begin
				cfg_reg <= pwdata[2:0];
			end
			if (xfer && pwrite && hit_cmd && !busy) begin
				cmd_reg <= pwdata[8:0];
			end
			// a completion in the clearing cycle keeps the flag
			if (set_done) begin
				done_reg <= 1'b1;
			end else if (clr_done) begin
				done_reg <= 1'b0;
			end
			case (state_reg)
				php_pkg::HS_IDLE: begin
					if (go) begin
						// strobe first, select one cycle later
						wr_rw_reg <= single ? pwdata[php_pkg::CMD_READ_BIT] :
							pwdata[php_pkg::CMD_READ_BIT];
						rd_ds_n_reg <= single ? 1'b0 : !pwdata[php_pkg::CMD_READ_BIT];
						d_oe_reg <= pwdata[php_pkg::CMD_READ_BIT] ? 2'b00 :
							(wide ? 2'b11 : 2'b01);
						state_reg <= php_pkg::HS_STROBE;
					end
				end
				php_pkg::HS_STROBE: begin
					cs_n_reg <= 1'b0;
					seen_low_reg <= 1'b0;
					state_reg <= php_pkg::HS_WAIT;
				end
				php_pkg::HS_WAIT: begin
					if (!port.ack_line) begin
						seen_low_reg <= 1'b1;
					end
					if (finish) begin
						if (is_read) begin
							rdata_reg <= port.data_line & (wide ? 16'hffff : 16'h00ff);
						end
						cs_n_reg <= 1'b1;
						wr_rw_reg <= 1'b1;
						rd_ds_n_reg <= 1'b1;
						d_oe_reg <= 2'b00;
						state_reg <= php_pkg::HS_IDLE;
					end
				end
				default: begin
					state_reg <= php_pkg::HS_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign port.cs_n = cs_n_reg;
	assign port.wr_rw = wr_rw_reg;
	assign port.rd_ds_n = rd_ds_n_reg;
	assign port.addr = cmd_reg[7:0];
	// stale write data may sit on the pins; only the enable matters
	assign port.host_d = wdata_reg;
	assign port.host_d_oe = d_oe_reg;
	assign port.serial_sel = cfg_reg[php_pkg::CFG_SERIAL_BIT];
	assign port.style = cfg_reg[php_pkg::CFG_STYLE_BIT];

endmodule : php_host

/* src/php_pkg.sv */
// constants, field layouts and state types of the parallel host port
// assumes both port ends and the bench run on one clock, pclk
package php_pkg;

	// ----------------------------------------------------------------
	// device address map
	// ----------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;
	localparam int ID_W = 4;
	localparam logic [7:0] ADDR_CHIP_CTRL = 8'h02;
	localparam logic [7:0] ADDR_OUT_I = 8'he0;
	localparam logic [7:0] ADDR_OUT_Q = 8'he2;
	localparam logic [7:0] ADDR_OUT_PWR = 8'he4;
	localparam logic [7:0] ADDR_FIRST_HANG = 8'he8;
	localparam int CC_ID_LSB = 0;
	localparam int CC_WIDE_BIT = 4;
	localparam logic [7:0] CC_RESET = 8'h00;
	// host keeps pclk below this; not enforced in logic
	localparam int PORT_CLK_MAX_MHZ = 100;

	// ----------------------------------------------------------------
	// host controller registers, reached over apb
	// ----------------------------------------------------------------
	localparam logic [11:0] HR_CMD = 12'h000;
	localparam logic [11:0] HR_WDATA = 12'h004;
	localparam logic [11:0] HR_RDATA = 12'h008;
	localparam logic [11:0] HR_STATUS = 12'h00c;
	localparam logic [11:0] HR_CONFIG = 12'h010;
	localparam int CMD_READ_BIT = 8;
	localparam int CMD_GO_BIT = 9;
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_DONE_BIT = 1;
	localparam int CFG_STYLE_BIT = 0;
	localparam int CFG_WIDE_BIT = 1;
	localparam int CFG_SERIAL_BIT = 2;
	localparam logic [2:0] CFG_RESET = 3'h0;

	typedef enum logic [2:0] {
		DV_IDLE, DV_BUSY, DV_WAIT, DV_DONE, DV_IGNORE, DV_HANG
	} php_dev_state_t;

	typedef enum logic [1:0] {
		HS_IDLE, HS_STROBE, HS_WAIT
	} php_host_state_t;

endpackage : php_pkg

/* src/php_port_if.sv */
// pins of the parallel host port between host and device
// assumes both ends on pclk; the bench drives dev_id straps
`timescale 1ns/1ps
interface php_port_if;
	logic cs_n;
	logic wr_rw;
	logic rd_ds_n;
	logic [7:0] addr;
	logic [15:0] host_d;
	logic [1:0] host_d_oe;
	logic [15:0] dev_d;
	logic [1:0] dev_d_oe;
	logic ack_o;
	logic ack_oe;
	logic serial_sel;
	logic style;
	logic [3:0] dev_id;
	logic [15:0] data_line;
	logic ack_line;

	// ----------------------------------------------------------------
	// wire resolution per byte lane; floating lanes read zero
	// ----------------------------------------------------------------
	assign data_line[7:0] = dev_d_oe[0] ? dev_d[7:0] : (host_d_oe[0] ? host_d[7:0] : 8'h00);
	assign data_line[15:8] = dev_d_oe[1] ? dev_d[15:8] : (host_d_oe[1] ? host_d[15:8] : 8'h00);
	// open drain with pull-up
	assign ack_line = !(ack_oe && !ack_o);

	modport device (
		input cs_n, wr_rw, rd_ds_n, addr, data_line, serial_sel, style, dev_id,
		output dev_d, dev_d_oe, ack_o, ack_oe
	);
	modport host (
		input data_line, ack_line,
		output cs_n, wr_rw, rd_ds_n, addr, host_d, host_d_oe, serial_sel, style
	);
endinterface : php_port_if

/* testbench/parallel_host_microport_bench.sv */
// self-checking bench: apb drives the host end, which talks to the device end
// assumes the bench answers the device's internal register port itself
`timescale 1ns/1ps
module parallel_host_microport_bench;
	logic pclk = 1'h0;
	logic presetn = 1'h0;
	logic ce = 1'h1, frz = 1'h0;
	logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, err, ok, busy;
	logic reg_req, reg_write, reg_wide, reg_done = 1'h0;
	logic [7:0] reg_addr, chip_ctrl, a;
	logic [15:0] reg_wdata, reg_rdata = 16'h0, q, v;
	logic [15:0] out_w [3];
	logic [15:0] rmem [256];
	logic [3:0] id_strap, id0;
	int n_errors = 0, checked = 0, n_req = 0, pend = 0, nr;

	always #4 pclk = ~pclk;

	php_port_if port_if();
	assign port_if.dev_id = id_strap;
	php_host i_php_host (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .port(port_if.host));
	php_device i_php_device (.pclk, .presetn, .ce, .port(port_if.device),
		.out_i_word(out_w[0]), .out_q_word(out_w[1]), .signal_strength_word(out_w[2]),
		.reg_req, .reg_write, .reg_wide, .reg_addr, .reg_wdata, .reg_rdata, .reg_done,
		.chip_ctrl, .busy);
	php_port_assertions i_php_port_assertions (.pclk, .presetn, .cs_n(port_if.cs_n),
		.wr_rw(port_if.wr_rw), .rd_ds_n(port_if.rd_ds_n), .addr(port_if.addr),
		.host_d_oe(port_if.host_d_oe), .dev_d_oe(port_if.dev_d_oe),
		.ack_line(port_if.ack_line), .serial_sel(port_if.serial_sel), .style(port_if.style));

	// ----------------------------------------------------------------
	// internal register side: random latency, garbage between answers
	// ----------------------------------------------------------------
	always @(posedge pclk) begin : resp
		bit fire;
		fire = (reg_req !== 1'h1 && pend == 1);
		if (reg_req === 1'h1) begin
			pend = $urandom_range(1, 3);
			n_req++;
		end else if (pend > 0)
			pend--;
		if (fire && reg_write)
			rmem[reg_addr] = reg_wdata;
		reg_done <= fire;
		reg_rdata <= fire ? rmem[reg_addr] : ~reg_rdata;
	end

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %0t %s: saw %h want %h", $time, what, seen, exp);
		end
	endtask : check

	task automatic stop_test;
		$display("checks %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : stop_test

	task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd);
		int k;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= ad;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'h1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'h1 && k < 50);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		if (k >= 50) begin
			check(32'h0, 32'h1, "apb answer timeout");
			stop_test();
		end
	endtask : apb

	// one port access; ok stays low when the device never completes
	task automatic port(input logic rdop, input logic [7:0] ad, input logic [15:0] wd);
		q = 16'hxxxx;
		ok = 1'h0;
		apb(1'h1, php_pkg::HR_WDATA, {16'h0, wd});
		apb(1'h1, php_pkg::HR_CMD, {22'h0, 1'h1, rdop, ad});
		// freeze once the device has taken the access; nothing may move
		if (frz) begin
			repeat (2) @(posedge pclk);
			ce <= 1'h0;
			repeat (8) @(posedge pclk);
			check(port_if.cs_n, 1'h0, "frozen host let go");
			check(busy, 1'h1, "frozen device finished");
			check(port_if.dev_d_oe, 2'h0, "frozen device drove data");
			ce <= 1'h1;
		end
		for (int k = 0; k < 40 && !ok; k++) begin
			apb(1'h0, php_pkg::HR_STATUS, 32'h0);
			ok = rd[php_pkg::ST_DONE_BIT];
		end
		if (ok) begin
			apb(1'h0, php_pkg::HR_RDATA, 32'h0);
			q = rd[15:0];
			apb(1'h1, php_pkg::HR_STATUS, 32'h2);
		end
	endtask : port

	// width goes to the device first; the low byte lane works in either width
	task automatic setup(input logic st, input logic wide, input logic ser);
		port(1'h0, php_pkg::ADDR_CHIP_CTRL, {11'h0, wide, id0});
		apb(1'h1, php_pkg::HR_CONFIG, {29'h0, ser, wide, st});
		repeat (4) @(posedge pclk);
	endtask : setup

	task automatic do_reset;
		@(posedge pclk);
		presetn <= 1'h0;
		repeat (8) @(posedge pclk);
		presetn <= 1'h1;
	endtask : do_reset

	function automatic logic [15:0] lane(input logic [15:0] x, input logic wide);
		return wide ? x : {8'h00, x[7:0]};
	endfunction : lane

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(82476));
		id0 = 4'($urandom_range(0, 15));
		id_strap = id0;
		for (int j = 0; j < 3; j++)
			out_w[j] = 16'($urandom);
		do_reset();
		apb(1'h0, php_pkg::HR_CONFIG, 32'h0);
		check(rd, {29'h0, php_pkg::CFG_RESET}, "config reset");
		apb(1'h0, 12'h014, 32'h0);
		check(err, 1'h1, "unmapped offset error");
		$display("test registers done");
		for (int m = 0; m < 4; m++) begin
			setup(m[0], m[1], 1'h0);
			check(chip_ctrl, {3'h0, m[1], id0}, "control byte held");
			port(1'h1, php_pkg::ADDR_CHIP_CTRL, 16'h0);
			check(q, {11'h0, m[1], id0}, "control byte");
			for (int j = 0; j < 3; j++) begin
				frz = j == 0;
				port(1'h1, php_pkg::ADDR_OUT_I + 8'(2 * j), 16'h0);
				check(q, lane(out_w[j], m[1]), "output word");
			end
			a = 8'($urandom_range(3, 8'hdf));
			v = 16'($urandom);
			nr = n_req;
			port(1'h0, a, v);
			port(1'h1, a, 16'h0);
			check(q, lane(v, m[1]), "register write and read back");
			check(n_req, nr + 2, "internal requests");
			check(reg_wide, m[1], "internal access width");
			$display("test mode %0d done", m);
		end
		for (int k = 0; k < 4; k++) begin
			id_strap <= id0;
			do_reset();
			setup(k == 2, 1'h0, k == 3);
			if (k == 0)
				id_strap <= ~id0;
			repeat (4) @(posedge pclk);
			nr = n_req;
			a = k == 0 ? 8'h10 : 8'($urandom_range(php_pkg::ADDR_FIRST_HANG, 8'hff));
			port(1'h1, k == 3 ? php_pkg::ADDR_CHIP_CTRL : a, 16'h0);
			check(ok, 1'h0, "refused access completed");
			check(n_req, nr, "refused access reached registers");
			check(rd[php_pkg::ST_BUSY_BIT], 1'h1, "host still waiting");
			check(busy, k != 3, "device state on refusal");
			$display("test refusal %0d done", k);
		end
		stop_test();
	end

	initial begin
		repeat (100000) @(posedge pclk);
		check(32'h0, 32'h1, "run limit reached");
		stop_test();
	end
endmodule : parallel_host_microport_bench

/* testbench/php_port_assertions.sv */
// concurrent checks on the wires between host and device ends
// assumes one clock, pclk, and presetn asynchronous active low
`timescale 1ns/1ps
module php_port_assertions (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic cs_n,
	input wire logic wr_rw,
	input wire logic rd_ds_n,
	input wire logic [7:0] addr,
	input wire logic [1:0] host_d_oe,
	input wire logic [1:0] dev_d_oe,
	input wire logic ack_line,
	input wire logic serial_sel,
	input wire logic style
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// ----------------------------------------------------------------
	// take and completion points of an access
	// ----------------------------------------------------------------
	sequence sep_take_s;
		!style && !cs_n && $fell(ack_line) && addr < php_pkg::ADDR_FIRST_HANG;
	endsequence
	sequence sep_rd_end_s;
		!style && !cs_n && wr_rw && $rose(ack_line);
	endsequence
	sequence sgl_rd_end_s;
		style && !cs_n && wr_rw && $fell(ack_line);
	endsequence

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	a_no_bus_fight: assert property (!(|(dev_d_oe & host_d_oe)))
		else $error("both ends drive the data bus");
	a_host_drive_write: assert property (host_d_oe != 2'h0 |-> !wr_rw)
		else $error("host drives data outside a write");
	a_dev_drive_read: assert property (dev_d_oe != 2'h0 |-> $past(!cs_n && wr_rw))
		else $error("device drives data outside a selected read");
	a_ack_needs_cs: assert property (!ack_line |-> $past(!cs_n))
		else $error("ready or acknowledge active without chip select");
	a_ack_release: assert property (style && !ack_line && (cs_n || rd_ds_n) |=> ack_line)
		else $error("acknowledge not released after deselect");
	a_ready_bounded: assert property (sep_take_s |-> ##[1:12] ack_line)
		else $error("ready not released after a mapped access");
	a_sep_read_data: assert property (sep_rd_end_s |-> dev_d_oe != 2'h0)
		else $error("ready released without read data");
	a_sgl_read_data: assert property (sgl_rd_end_s |-> dev_d_oe != 2'h0)
		else $error("acknowledge given without read data");
	a_hang_no_ack: assert property (style && !cs_n && addr >= php_pkg::ADDR_FIRST_HANG
		|-> ack_line)
		else $error("acknowledge given for an unmapped address");
	a_serial_quiet: assert property (serial_sel && $past(serial_sel, 3) |-> ack_line && dev_d_oe == 2'h0)
		else $error("port answers while serial select is high");
endmodule : php_port_assertions
